// ---- mad_decoder.sv ----
// Purpose: per-master first-level address decoder with boot map
// Assumes: requests synchronous to ref_clk, decoded result registered one cycle later
// Notes: boot pin captured on the first cycle after reset release
`timescale 1ns/1ps
`include "mad_defines.svh"
// Function
// - sixteen banks of 256 MB, chosen by address bits 31:28
// - banks one to seven go to external bus, each its own chip select
// - bank zero holds internal memories with second-level one-megabyte decoding
// - bank fifteen routes to the peripheral bridge
// - unassigned regions answer with an abort
// - each master has its own decoder instance, identical except that the boot window aborts for non-processor masters
// - processor masters see boot rom, external boot, or first_internal_sram at zero
// - remap active puts first internal sram at zero; software sets after boot
// - remap inactive: captured boot pin picks rom or external at zero
// - boot pin high: embedded rom at zero
// - boot pin low: external chip select zero at zero
// - boot window spans zero through 0x000F_FFFF
// - remapped memories stay reachable at their fixed bases
// - chip selects one to seven each own one 256 MB area; chip select zero only the boot window
// - chip select one served by sdram or static controller, others static
// - boot pin captured on first cycle after reset release, held until next reset
module mad_decoder (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    // configuration
    input  wire logic                     boot_media_select,
    input  wire logic                     remap,
    input  wire logic                     cs1_sdram_en,
    // master requests
    input  wire mad_pkg::mad_req_s        req   [`MAD_NUM_MASTERS],
    // routing results
    output mad_pkg::mad_route_s           route [`MAD_NUM_MASTERS]
);
    import mad_pkg::*;

    // idle route: no slave, no chip select, no abort
    localparam mad_route_s ROUTE_IDLE = '{slave: MAD_SEL_NONE, ext_cs: `MAD_EXT_CS_NONE, sdram_cs1: 1'b0, abort: 1'b0};

    logic boot_cap_done_ff;
    logic boot_rom_ff;

    // strap caught by a clocked process after release, never by reset itself
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            boot_cap_done_ff <= 1'b0;
            boot_rom_ff      <= 1'b0;
        end else if (!boot_cap_done_ff) begin
            boot_cap_done_ff <= 1'b1;
            boot_rom_ff      <= boot_media_select;
        end
    end

    function automatic mad_route_s decode(input logic [31:0] a, input logic is_cpu,
                                          input logic rmp, input logic brom, input logic sd1);
        mad_route_s r;
        logic [3:0] bank;
        logic [7:0] mb;
        r = ROUTE_IDLE;
        bank = a[`MAD_BANK_MSB:`MAD_BANK_LSB];
        mb   = a[`MAD_INT_MSB:`MAD_INT_LSB];
        if (bank == `MAD_BANK_INT) begin
            if (mb == `MAD_INT_BOOT && is_cpu) begin
                if (rmp) begin
                    r.slave = MAD_SEL_FIRST_INTERNAL_SRAM;
                end else if (brom) begin
                    r.slave = MAD_SEL_ROM;
                end else begin
                    r.slave  = MAD_SEL_EXT;
                    r.ext_cs = `MAD_EXT_CS_ZERO;
                end
            end else if (mb == `MAD_INT_ROM) begin
                r.slave = MAD_SEL_ROM;
            end else if (mb == `MAD_INT_FIRST_INTERNAL_SRAM) begin
                r.slave = MAD_SEL_FIRST_INTERNAL_SRAM;
            end else if (mb == `MAD_INT_SRAM1) begin
                r.slave = MAD_SEL_SRAM1;
            end else if (mb == `MAD_INT_USBH) begin
                r.slave = MAD_SEL_USBH;
            end else begin
                r.abort = 1'b1;
            end
        end else if (bank >= `MAD_BANK_EXT_LO && bank <= `MAD_BANK_EXT_HI) begin
            r.slave  = MAD_SEL_EXT;
            r.ext_cs = `MAD_EXT_CS_ZERO << bank;
            r.sdram_cs1 = sd1 && (bank == `MAD_BANK_EXT_LO);
        end else if (bank == `MAD_BANK_PERIPH) begin
            r.slave = MAD_SEL_PERIPH;
        end else begin
            r.abort = 1'b1;
        end
        return r;
    endfunction

    mad_route_s route_ff [`MAD_NUM_MASTERS];

    // one decoder per master, same map for all except the boot window, which aborts for non-processor masters
    for (genvar m = 0; m < `MAD_NUM_MASTERS; m++) begin : g_dec
        localparam logic [5:0] MBIT = 6'h01 << m;
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                route_ff[m] <= ROUTE_IDLE;
            end else if (req[m].valid) begin
                route_ff[m] <= decode(req[m].addr, |(MBIT & `MAD_CPU_MASTERS),
                                      remap, boot_rom_ff, cs1_sdram_en);
            end else begin
                route_ff[m] <= ROUTE_IDLE;
            end
        end
        assign route[m] = route_ff[m];

        property p_abort_nosel;
            @(posedge ref_clk) disable iff (!resetn)
            route_ff[m].abort |->
                (route_ff[m].slave == MAD_SEL_NONE && route_ff[m].ext_cs == `MAD_EXT_CS_NONE);
        endproperty
        a_abort_nosel : assert property (p_abort_nosel) else $error("abort with a slave selected");

        // two live chip selects would let two memories fight the data bus
        property p_cs_onehot;
            @(posedge ref_clk) disable iff (!resetn)
            (route_ff[m].slave == MAD_SEL_EXT) ? $onehot(route_ff[m].ext_cs)
                                                : (route_ff[m].ext_cs == `MAD_EXT_CS_NONE);
        endproperty
        a_cs_onehot : assert property (p_cs_onehot) else $error("chip select not one-hot");

        property p_sdram_only_cs1;
            @(posedge ref_clk) disable iff (!resetn)
            route_ff[m].sdram_cs1 |-> (route_ff[m].ext_cs == `MAD_EXT_CS_ONE);
        endproperty
        a_sdram_only_cs1 : assert property (p_sdram_only_cs1) else $error("sdram flag off chip select one");
    end

    property p_ext_bank;
        @(posedge ref_clk) disable iff (!resetn)
        (req[2].valid && req[2].addr[31:28] == 4'h3) |=> (route_ff[2].ext_cs == 8'h08);
    endproperty
    a_ext_bank : assert property (p_ext_bank) else $error("bank three chip select wrong");

    property p_periph;
        @(posedge ref_clk) disable iff (!resetn)
        (req[0].valid && req[0].addr[31:28] == 4'hF) |=> (route_ff[0].slave == MAD_SEL_PERIPH);
    endproperty
    a_periph : assert property (p_periph) else $error("bank fifteen not peripheral");

    property p_unused;
        @(posedge ref_clk) disable iff (!resetn)
        (req[1].valid && req[1].addr[31:28] == 4'h9) |=> route_ff[1].abort;
    endproperty
    a_unused : assert property (p_unused) else $error("unused bank did not abort");

    property p_remap;
        @(posedge ref_clk) disable iff (!resetn)
        (req[0].valid && req[0].addr[31:20] == 12'h000 && remap) |=> (route_ff[0].slave == MAD_SEL_FIRST_INTERNAL_SRAM);
    endproperty
    a_remap : assert property (p_remap) else $error("remap did not select first_internal_sram");

    property p_boot_rom;
        @(posedge ref_clk) disable iff (!resetn)
        (req[1].valid && req[1].addr[31:20] == 12'h000 && !remap && boot_rom_ff) |=>
            (route_ff[1].slave == MAD_SEL_ROM);
    endproperty
    a_boot_rom : assert property (p_boot_rom) else $error("rom boot not selected");

    property p_boot_ext;
        @(posedge ref_clk) disable iff (!resetn)
        (req[0].valid && req[0].addr[31:20] == 12'h000 && !remap && !boot_rom_ff) |=>
            (route_ff[0].ext_cs == 8'h01);
    endproperty
    a_boot_ext : assert property (p_boot_ext) else $error("external boot not selected");

    property p_boot_hold;
        @(posedge ref_clk) disable iff (!resetn)
        boot_cap_done_ff |=> $stable(boot_rom_ff);
    endproperty
    a_boot_hold : assert property (p_boot_hold) else $error("boot strap changed after capture");

    property p_fixed_rom;
        @(posedge ref_clk) disable iff (!resetn)
        (req[3].valid && req[3].addr[31:20] == 12'h010) |=> (route_ff[3].slave == MAD_SEL_ROM);
    endproperty
    a_fixed_rom : assert property (p_fixed_rom) else $error("rom not at fixed base");

    property p_fixed_first_internal_sram;
        @(posedge ref_clk) disable iff (!resetn)
        (req[1].valid && req[1].addr[31:20] == 12'h020) |=> (route_ff[1].slave == MAD_SEL_FIRST_INTERNAL_SRAM);
    endproperty
    a_fixed_first_internal_sram : assert property (p_fixed_first_internal_sram) else $error("first_internal_sram not at fixed base");

    property p_sram1;
        @(posedge ref_clk) disable iff (!resetn)
        (req[5].valid && req[5].addr[31:20] == 12'h030) |=> (route_ff[5].slave == MAD_SEL_SRAM1);
    endproperty
    a_sram1 : assert property (p_sram1) else $error("sram1 not decoded");

    property p_usbh;
        @(posedge ref_clk) disable iff (!resetn)
        (req[4].valid && req[4].addr[31:20] == 12'h050) |=> (route_ff[4].slave == MAD_SEL_USBH);
    endproperty
    a_usbh : assert property (p_usbh) else $error("usb host window not decoded");

    // the boot window belongs to the processor masters only
    property p_noncpu_boot;
        @(posedge ref_clk) disable iff (!resetn)
        (req[2].valid && req[2].addr[31:20] == 12'h000) |=> route_ff[2].abort;
    endproperty
    a_noncpu_boot : assert property (p_noncpu_boot) else $error("boot window seen by a dma master");

    property p_boot_window_end;
        @(posedge ref_clk) disable iff (!resetn)
        (req[1].valid && req[1].addr == 32'h000F_FFFF) |=> (route_ff[1].slave != MAD_SEL_NONE);
    endproperty
    a_boot_window_end : assert property (p_boot_window_end) else $error("last boot window byte unmapped");

    property p_sdram_cs1;
        @(posedge ref_clk) disable iff (!resetn)
        (req[0].valid && req[0].addr[31:28] == `MAD_BANK_EXT_LO && cs1_sdram_en) |=> route_ff[0].sdram_cs1;
    endproperty
    a_sdram_cs1 : assert property (p_sdram_cs1) else $error("chip select one not given to sdram");

    // identical requests on non-processor masters four and five must land identically
    sequence s_twin_req;
        req[4].valid && req[5].valid && (req[4].addr == req[5].addr);
    endsequence

    sequence s_twin_route;
        route_ff[4] == route_ff[5];
    endsequence

    property p_same_map;
        @(posedge ref_clk) disable iff (!resetn)
        s_twin_req |=> s_twin_route;
    endproperty
    a_same_map : assert property (p_same_map) else $error("masters decode one address differently");
endmodule // mad_decoder

// ---- mad_defines.svh ----
// Purpose: constants of the matrix address decoder
// Assumes: 32-bit byte addresses
// Notes: bank is the top address nibble
`ifndef MAD_DEFINES_SVH
`define MAD_DEFINES_SVH
`define MAD_NUM_MASTERS   6
`define MAD_BANK_MSB      31
`define MAD_BANK_LSB      28
`define MAD_BANK_INT      4'h0
`define MAD_BANK_EXT_LO   4'h1
`define MAD_BANK_EXT_HI   4'h7
`define MAD_BANK_PERIPH   4'hF
`define MAD_INT_MSB       27
`define MAD_INT_LSB       20
`define MAD_INT_BOOT      8'h00
`define MAD_INT_ROM       8'h10
`define MAD_INT_FIRST_INTERNAL_SRAM     8'h20
`define MAD_INT_SRAM1     8'h30
`define MAD_INT_USBH      8'h50
`define MAD_EXT_CS_NONE   8'h00
`define MAD_EXT_CS_ZERO   8'h01
`define MAD_EXT_CS_ONE    8'h02
`define MAD_CPU_MASTERS   6'h03
`endif

// ---- mad_master_model.sv ----
// Purpose: bus master stand-in, one request per cycle
// Assumes: bench drives valid and addr at the falling edge
// Notes: idle address shows the inverse so stale values never match
`timescale 1ns/1ps
module mad_master_model (
    // request from bench
    input  wire logic        valid,
    input  wire logic [31:0] addr,
    // master bus
    output mad_pkg::mad_req_s req
);
    import mad_pkg::*;
    assign req = valid ? {1'b1, addr} : {1'b0, ~addr};
endmodule // mad_master_model

// ---- mad_pkg.sv ----
// Purpose: types of the matrix address decoder
// Assumes: mad_defines.svh provides constants
// Notes: none
`include "mad_defines.svh"
package mad_pkg;
    typedef enum logic [3:0] {
        MAD_SEL_NONE   = 4'b0000,
        MAD_SEL_ROM    = 4'b0001,
        MAD_SEL_FIRST_INTERNAL_SRAM  = 4'b0010,
        MAD_SEL_SRAM1  = 4'b0011,
        MAD_SEL_USBH   = 4'b0100,
        MAD_SEL_EXT    = 4'b0101,
        MAD_SEL_PERIPH = 4'b0110
    } mad_slave_e;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } mad_req_s;
    typedef struct packed {
        mad_slave_e  slave;
        logic [7:0]  ext_cs;
        logic        sdram_cs1;
        logic        abort;
    } mad_route_s;
endpackage

// ---- matrix_address_decoder_boot_map_test.sv ----
// Purpose: random and corner checks of the per-master decoder
// Assumes: one cycle latency, strap taken on first edge after reset
// Notes: expectations rebuilt from the address map, not from the design
`timescale 1ns/1ps
`include "mad_defines.svh"
module matrix_address_decoder_boot_map_test;
    import mad_pkg::*;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        boot_media_select = 1'b1;
    logic        remap = 1'b0;
    logic        cs1_sdram_en = 1'b0;
    logic        strap = 1'b1;
    logic [5:0]  valid = 6'h00;
    logic [31:0] addr [`MAD_NUM_MASTERS] = '{default: 32'h0000_0000};
    logic [31:0] corner [8] = '{32'h000F_FFFF, 32'h0010_0000, 32'h0100_0000, 32'h0200_0000,
                                32'h0300_0000, 32'h0500_0000, 32'h1000_0000, 32'hFFFF_FFFF};
    logic [31:0] seed = 32'h0000_dde4;
    mad_req_s    req [`MAD_NUM_MASTERS];
    mad_route_s  route [`MAD_NUM_MASTERS];
    mad_route_s  exp_q [`MAD_NUM_MASTERS];
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #20 ref_clk = ~ref_clk;
    for (genvar g = 0; g < `MAD_NUM_MASTERS; g++) begin : g_mst
        mad_master_model u_mst (.valid(valid[g]), .addr(addr[g]), .req(req[g]));
    end
    mad_decoder u_dut (.ref_clk(ref_clk), .resetn(resetn), .boot_media_select(boot_media_select),
        .remap(remap), .cs1_sdram_en(cs1_sdram_en), .req(req), .route(route));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic mad_route_s want(input logic v, input logic [31:0] a, input int m);
        mad_route_s r;
        r = '0;
        if (v) begin
            case (a[31:28])
                4'h0: case (a[27:20])
                    8'h00: r = (m > 1) ? 14'h0001 : remap ? {MAD_SEL_FIRST_INTERNAL_SRAM, 10'h000}
                        : strap ? {MAD_SEL_ROM, 10'h000} : {MAD_SEL_EXT, 8'h01, 2'b00};
                    8'h10: r.slave = MAD_SEL_ROM;
                    8'h20: r.slave = MAD_SEL_FIRST_INTERNAL_SRAM;
                    8'h30: r.slave = MAD_SEL_SRAM1;
                    8'h50: r.slave = MAD_SEL_USBH;
                    default: r.abort = 1'b1;
                endcase
                4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE: r.abort = 1'b1;
                4'hF: r.slave = MAD_SEL_PERIPH;
                default: r = {MAD_SEL_EXT, 8'h01 << a[30:28], (a[31:28] == 4'h1) && cs1_sdram_en, 1'b0};
            endcase
        end
        return r;
    endfunction
    task automatic check_route(input mad_route_s e, input mad_route_s g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD route expected %h seen %h", e, g);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        resetn = 1'b0;
        boot_media_select = s;
        strap = s;
        remap = 1'b0;
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        boot_media_select = ~s;
    endtask
    task automatic run(input int n, input string name);
        for (int i = 0; i <= n; i++) begin
            @(negedge ref_clk);
            for (int m = 0; m < `MAD_NUM_MASTERS; m++) begin
                if (i > 0) check_route(exp_q[m], route[m]);
                seed = xs(seed);
                valid[m] = (i < n) && (seed[3:0] != 4'h0);
                addr[m] = {seed[31:28], seed[9] ? seed[27:20] : {1'b0, seed[14:12], 4'h0}, seed[19:0]};
                if (i < 8) addr[m] = corner[i];
                exp_q[m] = want(valid[m], addr[m], m);
            end
        end
        $display("test %s done, mismatches %0d", name, mismatches);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        do_reset(1'b1);
        run(300, "rom boot");
        cs1_sdram_en = 1'b1;
        run(200, "sdram cs1");
        remap = 1'b1;
        run(200, "remap");
        do_reset(1'b0);
        run(300, "external boot");
        finish_test();
    end
endmodule // matrix_address_decoder_boot_map_test
